// ### rtl/speed_cmp_cfg.svh
`ifndef SPEED_CMP_CFG_SVH
`define SPEED_CMP_CFG_SVH

`define NUM_CH         3
`define VAL_W          20
`define CH_STRIDE      8'h10
`define OFS_CFG        8'h00
`define OFS_UPPER      8'h04
`define OFS_LOWER      8'h08
`define OFS_STATUS     8'h30
`define OFS_MASK       8'h34
`define OFS_STATE      8'h38

`define F_SEL_LSB      0
`define F_MODE_LSB     2
`define F_HYST_LSB     4
`define F_DLY_LSB      9
`define F_WID_LSB      14

`define CFG_RESET      22'h000000
`define THR_RESET      20'h00000
`define THR_MAX        20'hf423f
`define HYST_MAX       5'h14
`define DLY_MAX_STEPS  5'h14
`define WID_MAX_STEPS  8'hc8
`define PCT_FULL       7'h64

`define CLK_PERIOD_NS  25
`define MS_NS          1000000
`define DLY_STEP_MS    10'h032
`define WID_STEP_MS    11'h00a

`endif

// ### rtl/speed_cmp_pkg.sv
package speed_cmp_pkg;

	typedef enum logic [1:0] {
		JUDGE_UPPER = 2'h0,
		JUDGE_LOWER = 2'h1,
		JUDGE_OK    = 2'h2,
		JUDGE_ERROR = 2'h3
	} judge_t;

	typedef enum logic [1:0] {
		MODE_AUTO  = 2'h0,
		MODE_HOLD  = 2'h1,
		MODE_PULSE = 2'h2
	} out_mode_t;

	// Layout matches the channel configuration word, lsb last.
	typedef struct packed {
		logic [7:0] width;
		logic [4:0] delay;
		logic [4:0] hyst;
		out_mode_t  mode;
		judge_t     sel;
	} chan_cfg_t;

	typedef struct packed {
		logic link_err;
		logic setup_err;
		logic input_err;
	} op_error_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage: speed_cmp_pkg

// ### rtl/limit_channel.sv
`timescale 1ns/100ps
`include "speed_cmp_cfg.svh"

module limit_channel
	import speed_cmp_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      reset,
	input  wire logic      ms_tick,
	input  wire chan_cfg_t cfg,
	input  wire logic      cond,
	input  wire logic      clr,
	output logic           on_q
);

	logic [10:0] dly_q;
	logic [11:0] pul_q;
	logic        qual_prev_q;
	logic        on_d;

	wire [10:0] dly_lim = 11'(cfg.delay) * 11'(`DLY_STEP_MS);
	wire [11:0] wid_lim = 12'(cfg.width) * 12'(`WID_STEP_MS);
	wire        qual    = cond && (dly_q >= dly_lim);
	wire        fire    = qual && !qual_prev_q && (cfg.width != 8'h00);

	always_comb begin
		unique case (cfg.mode)
			MODE_HOLD:  on_d = qual || (on_q && !clr);
			MODE_PULSE: on_d = fire || (on_q && (pul_q < wid_lim));
			default:    on_d = on_q ? cond : qual;
		endcase
	end

	// The delay counter restarts on any gap in the condition.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dly_q       <= '0;
			pul_q       <= '0;
			qual_prev_q <= 1'b0;
			on_q        <= 1'b0;
		end else begin
			dly_q       <= !cond ? '0 : (ms_tick && dly_q < dly_lim) ? dly_q + 11'h001 : dly_q;
			pul_q       <= fire ? '0 : (ms_tick && on_q && pul_q < wid_lim) ? pul_q + 12'h001 : pul_q;
			qual_prev_q <= qual;
			on_q        <= on_d;
		end
	end

	property p_hold_keep;
		@(posedge sys_clk) disable iff (reset)
		on_q && cfg.mode == MODE_HOLD && !clr |=> on_q;
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("held output dropped");

	property p_pulse_start;
		@(posedge sys_clk) disable iff (reset)
		$rose(on_q) && cfg.mode == MODE_PULSE |-> cfg.width != 8'h00 && !$past(qual_prev_q);
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse without edge");

	property p_pulse_end;
		@(posedge sys_clk) disable iff (reset)
		cfg.mode == MODE_PULSE && on_q && pul_q >= wid_lim && !fire |=> !on_q;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");

	property p_delay;
		@(posedge sys_clk) disable iff (reset)
		$rose(on_q) |-> $past(dly_q) >= $past(dly_lim) && $past(cond);
	endproperty
	a_delay: assert property (p_delay) else $error("output before delay");

	property p_once;
		@(posedge sys_clk) disable iff (reset)
		cfg.mode == MODE_PULSE && qual && qual_prev_q |=> !$rose(on_q);
	endproperty
	a_once: assert property (p_once) else $error("pulse retriggered");

	property p_auto_release;
		@(posedge sys_clk) disable iff (reset)
		cfg.mode == MODE_AUTO && !cond |=> !on_q;
	endproperty
	a_auto_release: assert property (p_auto_release) else $error("auto not released");

endmodule: limit_channel

// ### rtl/speed_limit_comparator_outputs.sv
`timescale 1ns/100ps
`include "speed_cmp_cfg.svh"

module speed_limit_comparator_outputs
	import speed_cmp_pkg::*;
#(
	parameter int MS_TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire reg_req_t         reg_req,
	output logic [31:0]           reg_rdata,
	input  wire logic [`VAL_W-1:0] meas_value,
	input  wire op_error_t        op_error,
	input  wire logic             ss_mode,
	input  wire logic             section_start,
	input  wire logic             section_stop,
	input  wire logic             panel_reset,
	output logic [`NUM_CH-1:0]    relay_out,
	output logic                  irq
);

	localparam int NCH    = `NUM_CH;
	localparam int TICK_W = $clog2(MS_TICK_CYCLES);

	logic [TICK_W-1:0] tick_cnt_q;
	logic              tick_q;
	logic              run_q;
	logic              irq_q;
	logic [31:0]       rdata_q;
	chan_cfg_t         cfg_q   [NCH];
	logic [`VAL_W-1:0] upper_q [NCH];
	logic [`VAL_W-1:0] lower_q [NCH];
	logic [NCH-1:0]    relay_q;
	logic [NCH-1:0]    status_q;
	logic [NCH-1:0]    mask_q;

	logic [NCH-1:0]    ch_on;
	logic [NCH-1:0]    cond;
	logic [NCH-1:0]    other_act;
	logic [NCH-1:0]    act_ul;
	logic [NCH-1:0]    hit_cfg;
	logic [NCH-1:0]    hit_up;
	logic [NCH-1:0]    hit_lo;
	logic [NCH-1:0]    up_raw;
	logic [NCH-1:0]    lo_raw;
	logic [NCH-1:0]    up_rel;
	logic [NCH-1:0]    lo_rel;
	logic [NCH-1:0]    use_hyst;
	logic [31:0]       ch_rd   [NCH];
	logic [31:0]       rd_acc  [NCH+1];

	wire [26:0]    meas_x100  = 27'(meas_value) * 27'(`PCT_FULL);
	wire           err_any    = op_error.input_err || op_error.setup_err;
	wire           ss_eval    = !ss_mode || section_start || section_stop;
	wire           hold_clr   = panel_reset && !(ss_mode && run_q);
	wire [NCH-1:0] relay_d    = ss_eval ? ch_on : relay_q;
	wire [NCH-1:0] rise       = relay_d & ~relay_q;
	wire           hit_status = reg_req.addr == `OFS_STATUS;
	wire           hit_mask   = reg_req.addr == `OFS_MASK;
	wire           hit_state  = reg_req.addr == `OFS_STATE;
	wire [NCH-1:0] w1c        = (reg_req.wr && hit_status) ? reg_req.wdata[NCH-1:0] : '0;
	wire           tick_wrap  = tick_cnt_q == TICK_W'(MS_TICK_CYCLES - 1);

	// Out-of-range settings are clamped so the timers never exceed their span.
	function automatic chan_cfg_t cfg_clamp(input logic [31:0] w);
		chan_cfg_t c;
		c = chan_cfg_t'(w[$bits(chan_cfg_t)-1:0]);
		if (c.hyst > `HYST_MAX) begin
			c.hyst = `HYST_MAX;
		end
		if (c.delay > `DLY_MAX_STEPS) begin
			c.delay = `DLY_MAX_STEPS;
		end
		if (c.width > `WID_MAX_STEPS) begin
			c.width = `WID_MAX_STEPS;
		end
		return c;
	endfunction: cfg_clamp

	function automatic logic [`VAL_W-1:0] thr_clamp(input logic [31:0] w);
		return (w[`VAL_W-1:0] > `THR_MAX) ? `THR_MAX : w[`VAL_W-1:0];
	endfunction: thr_clamp

	assign rd_acc[0] = (hit_status ? 32'(status_q) : 32'h0)
		| (hit_mask ? 32'(mask_q) : 32'h0)
		| (hit_state ? 32'({run_q, relay_q}) : 32'h0);

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		assign hit_cfg[i] = reg_req.addr == 8'(i) * `CH_STRIDE + `OFS_CFG;
		assign hit_up[i]  = reg_req.addr == 8'(i) * `CH_STRIDE + `OFS_UPPER;
		assign hit_lo[i]  = reg_req.addr == 8'(i) * `CH_STRIDE + `OFS_LOWER;

		assign up_raw[i]   = meas_value >= upper_q[i];
		assign lo_raw[i]   = lower_q[i] > meas_value;
		// Release thresholds are compared scaled by 100 to avoid a divider.
		assign up_rel[i]   = meas_x100 >= 27'(upper_q[i]) * (27'(`PCT_FULL) - 27'(cfg_q[i].hyst));
		assign lo_rel[i]   = meas_x100 < 27'(lower_q[i]) * (27'(`PCT_FULL) + 27'(cfg_q[i].hyst));
		assign use_hyst[i] = cfg_q[i].mode == MODE_AUTO && ch_on[i];

		assign act_ul[i]    = relay_q[i]
			&& (cfg_q[i].sel == JUDGE_UPPER || cfg_q[i].sel == JUDGE_LOWER);
		assign other_act[i] = |(act_ul & ~(NCH'(1) << i));

		assign cond[i] = (cfg_q[i].sel == JUDGE_UPPER) ? (use_hyst[i] ? up_rel[i] : up_raw[i])
			: (cfg_q[i].sel == JUDGE_LOWER) ? (use_hyst[i] ? lo_rel[i] : lo_raw[i])
			: (cfg_q[i].sel == JUDGE_OK) ? !other_act[i]
			: err_any;

		assign ch_rd[i] = hit_cfg[i] ? 32'(cfg_q[i])
			: hit_up[i] ? 32'(upper_q[i])
			: hit_lo[i] ? 32'(lower_q[i])
			: 32'h0;
		assign rd_acc[i+1] = rd_acc[i] | ch_rd[i];

		limit_channel u_chan (
			.sys_clk (sys_clk),
			.reset   (reset),
			.ms_tick (tick_q),
			.cfg     (cfg_q[i]),
			.cond    (cond[i]),
			.clr     (hold_clr),
			.on_q    (ch_on[i])
		);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TICK_W'(1);
			tick_q     <= tick_wrap;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NCH; i++) begin
				cfg_q[i]   <= chan_cfg_t'(`CFG_RESET);
				upper_q[i] <= `THR_RESET;
				lower_q[i] <= `THR_RESET;
			end
		end else if (reg_req.wr) begin
			for (int i = 0; i < NCH; i++) begin
				if (hit_cfg[i]) begin
					cfg_q[i] <= cfg_clamp(reg_req.wdata);
				end
				if (hit_up[i]) begin
					upper_q[i] <= thr_clamp(reg_req.wdata);
				end
				if (hit_lo[i]) begin
					lower_q[i] <= thr_clamp(reg_req.wdata);
				end
			end
		end
	end

	// Relay contacts only follow the channels when evaluation is allowed.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			relay_q <= '0;
			run_q   <= 1'b0;
		end else begin
			relay_q <= relay_d;
			run_q   <= ss_mode && (section_start || (run_q && !section_stop));
		end
	end

	// A new assertion event wins over a write-one-to-clear in the same cycle.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			status_q <= '0;
			mask_q   <= '0;
			irq_q    <= 1'b0;
			rdata_q  <= 32'h0;
		end else begin
			status_q <= (status_q & ~w1c) | rise;
			if (reg_req.wr && hit_mask) begin
				mask_q <= reg_req.wdata[NCH-1:0];
			end
			irq_q   <= |(status_q & mask_q);
			rdata_q <= reg_req.rd ? rd_acc[NCH] : 32'h0;
		end
	end

	assign reg_rdata = rdata_q;
	assign relay_out = relay_q;
	assign irq       = irq_q;

	property p_upper;
		@(posedge sys_clk) disable iff (reset)
		(!ss_mode && cfg_q[0].sel == JUDGE_UPPER && cfg_q[0].mode == MODE_AUTO
			&& cfg_q[0].delay == 5'h00 && up_raw[0])[*2] |-> ##1 relay_q[0];
	endproperty
	a_upper: assert property (p_upper) else $error("upper limit not asserted");

	property p_lower;
		@(posedge sys_clk) disable iff (reset)
		(!ss_mode && cfg_q[0].sel == JUDGE_LOWER && cfg_q[0].mode == MODE_AUTO
			&& cfg_q[0].delay == 5'h00 && lo_raw[0])[*2] |-> ##1 relay_q[0];
	endproperty
	a_lower: assert property (p_lower) else $error("lower limit not asserted");

	property p_ok_drop;
		@(posedge sys_clk) disable iff (reset)
		(!ss_mode && cfg_q[0].sel == JUDGE_OK && cfg_q[0].mode == MODE_AUTO
			&& other_act[0])[*2] |-> ##1 !relay_q[0];
	endproperty
	a_ok_drop: assert property (p_ok_drop) else $error("normal output not dropped");

	property p_ok_other;
		@(posedge sys_clk) disable iff (reset)
		(!ss_mode && cfg_q[1].sel == JUDGE_OK && cfg_q[1].mode == MODE_AUTO
			&& other_act[1])[*2] |-> ##1 !relay_q[1];
	endproperty
	a_ok_other: assert property (p_ok_other) else $error("normal output on with alarm");

	property p_link_err;
		@(posedge sys_clk) disable iff (reset)
		(!ss_mode && cfg_q[0].sel == JUDGE_ERROR && cfg_q[0].mode == MODE_AUTO
			&& !op_error.input_err && !op_error.setup_err)[*2] |-> ##1 !relay_q[0];
	endproperty
	a_link_err: assert property (p_link_err) else $error("error output on link error");

	property p_hyst;
		@(posedge sys_clk) disable iff (reset)
		cfg_q[0].sel == JUDGE_UPPER && cfg_q[0].mode == MODE_AUTO && ch_on[0] && up_rel[0]
			|=> ch_on[0];
	endproperty
	a_hyst: assert property (p_hyst) else $error("released inside hysteresis");

	property p_ss_sync;
		@(posedge sys_clk) disable iff (reset)
		ss_mode && !section_start && !section_stop |=> $stable(relay_q);
	endproperty
	a_ss_sync: assert property (p_ss_sync) else $error("relay moved between events");

	property p_clr_block;
		@(posedge sys_clk) disable iff (reset)
		ss_mode && run_q |-> !hold_clr;
	endproperty
	a_clr_block: assert property (p_clr_block) else $error("reset during running section");

	property p_tick;
		@(posedge sys_clk) disable iff (reset)
		tick_q |-> tick_cnt_q == '0 ##1 !tick_q;
	endproperty
	a_tick: assert property (p_tick) else $error("tick spacing wrong");

	property p_irq;
		@(posedge sys_clk) disable iff (reset)
		$rose(relay_q[0]) && mask_q[0] |-> ##1 irq_q;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule: speed_limit_comparator_outputs

// ### verification/relay_load_model.sv
`timescale 1ns/100ps

module relay_load_model (
	input  wire logic            sys_clk,
	input  wire logic            reset,
	input  wire logic [2:0]      contact,
	output logic      [2:0][7:0] closures
);
	logic [2:0] contact_q;

	// Each contact is a separate make circuit, so every closure is counted on its own.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			contact_q <= 3'h0;
			closures  <= '0;
		end else begin
			contact_q <= contact;
			for (int i = 0; i < 3; i++) begin
				if (contact[i] && !contact_q[i]) begin
					closures[i] <= closures[i] + 8'h01;
				end
			end
		end
	end
endmodule: relay_load_model

// ### verification/speed_limit_comparator_outputs_tb_top.sv
`timescale 1ns/100ps

module speed_limit_comparator_outputs_tb_top
	import speed_cmp_pkg::*;
;
	logic            sys_clk;
	logic            reset;
	reg_req_t        reg_req;
	logic [31:0]     reg_rdata;
	logic [19:0]     meas_value;
	op_error_t       op_error;
	logic            ss_mode;
	logic            section_start;
	logic            section_stop;
	logic            panel_reset;
	logic [2:0]      relay_out;
	logic            irq;
	logic [2:0][7:0] closures;
	logic [7:0]      c0;
	int              miscompares;
	int              n_compared;

	// A 4-cycle millisecond keeps the 50 ms delay steps short enough to simulate.
	speed_limit_comparator_outputs #(.MS_TICK_CYCLES(4)) speed_limit_comparator_outputs_i (
		.sys_clk       (sys_clk),
		.reset         (reset),
		.reg_req       (reg_req),
		.reg_rdata     (reg_rdata),
		.meas_value    (meas_value),
		.op_error      (op_error),
		.ss_mode       (ss_mode),
		.section_start (section_start),
		.section_stop  (section_stop),
		.panel_reset   (panel_reset),
		.relay_out     (relay_out),
		.irq           (irq)
	);

	relay_load_model relay_load_model_i (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.contact  (relay_out),
		.closures (closures)
	);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask: tick

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask: cmp

	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		tick(1);
		reg_req.wr <= 1'b0;
		// One idle edge keeps the strobe from being lowered and raised in one step.
		tick(1);
	endtask: wr

	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task rd(input logic [7:0] a, input logic [31:0] e);
		reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		tick(1);
		reg_req.rd <= 1'b0;
		#1 cmp("reg_rdata", e, reg_rdata);
	endtask: rd

	task mchk(input logic [19:0] v, input int n, input logic [2:0] e);
		meas_value <= v;
		tick(n);
		#1 cmp("relay_out", {29'h0, e}, relay_out);
	endtask: mchk

	task ev(input logic [2:0] k);
		{section_start, section_stop, panel_reset} <= k;
		tick(1);
		{section_start, section_stop, panel_reset} <= 3'h0;
		tick(2);
	endtask: ev

	function automatic logic [31:0] cw(input logic [1:0] s, input logic [1:0] m,
		input logic [4:0] h, input logic [4:0] d, input logic [7:0] w);
		cw = {10'h0, w, d, h, m, s};
	endfunction: cw

	task results;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask: results

	initial begin
		tick(20000);
		miscompares++;
		results;
	end

	initial begin
		reset = 1'b1;
		reg_req = '0;
		meas_value = 20'h0;
		op_error = '0;
		ss_mode = 1'b0;
		{section_start, section_stop, panel_reset} = 3'h0;
		miscompares = 0;
		n_compared = 0;
		tick(5);
		reset <= 1'b0;
		tick(1);
		rd(8'h00, 32'h0);
		wr(8'h04, 32'h000fffff);
		rd(8'h04, 32'h000f423f);
		rd(8'hfc, 32'h0);
		$display("test registers done");
		wr(8'h00, cw(JUDGE_UPPER, MODE_AUTO, 5'h0, 5'h0, 8'h0));
		wr(8'h04, 32'd1000);
		wr(8'h10, cw(JUDGE_LOWER, MODE_AUTO, 5'h0, 5'h0, 8'h0));
		wr(8'h18, 32'd500);
		wr(8'h20, cw(JUDGE_OK, MODE_AUTO, 5'h0, 5'h0, 8'h0));
		mchk(20'd700, 6, 3'b100);
		mchk(20'd1000, 6, 3'b001);
		mchk(20'd999, 6, 3'b100);
		mchk(20'd499, 6, 3'b010);
		mchk(20'd500, 6, 3'b100);
		wr(8'h00, cw(JUDGE_UPPER, MODE_AUTO, 5'h0a, 5'h0, 8'h0));
		mchk(20'd1000, 6, 3'b001);
		mchk(20'd950, 6, 3'b001);
		mchk(20'd850, 6, 3'b100);
		$display("test judgements done");
		wr(8'h20, cw(JUDGE_ERROR, MODE_AUTO, 5'h0, 5'h0, 8'h0));
		op_error <= 3'b100;
		mchk(20'd850, 6, 3'b000);
		op_error <= 3'b001;
		mchk(20'd850, 6, 3'b100);
		op_error <= 3'b010;
		mchk(20'd850, 6, 3'b100);
		op_error <= 3'b000;
		mchk(20'd600, 6, 3'b000);
		$display("test errors done");
		ss_mode <= 1'b1;
		mchk(20'd1000, 10, 3'b000);
		ev(3'b100);
		#1 cmp("relay_out", 32'h1, relay_out);
		mchk(20'd600, 10, 3'b001);
		ev(3'b010);
		#1 cmp("relay_out", 32'h0, relay_out);
		ss_mode <= 1'b0;
		$display("test section done");
		wr(8'h00, cw(JUDGE_UPPER, MODE_HOLD, 5'h0, 5'h0, 8'h0));
		mchk(20'd1000, 6, 3'b001);
		mchk(20'd600, 20, 3'b001);
		ss_mode <= 1'b1;
		ev(3'b100);
		ev(3'b001);
		#1 cmp("relay_out", 32'h1, relay_out);
		rd(8'h38, 32'h9);
		ev(3'b010);
		ss_mode <= 1'b0;
		ev(3'b001);
		mchk(20'd600, 4, 3'b000);
		$display("test hold done");
		wr(8'h00, cw(JUDGE_UPPER, MODE_AUTO, 5'h0, 5'h1, 8'h0));
		mchk(20'd1000, 150, 3'b000);
		mchk(20'd600, 4, 3'b000);
		mchk(20'd1000, 150, 3'b000);
		mchk(20'd1000, 70, 3'b001);
		mchk(20'd600, 6, 3'b000);
		$display("test delay done");
		wr(8'h00, cw(JUDGE_UPPER, MODE_PULSE, 5'h0, 5'h0, 8'h02));
		c0 = closures[0];
		mchk(20'd1000, 6, 3'b001);
		mchk(20'd1000, 54, 3'b001);
		mchk(20'd1000, 50, 3'b000);
		mchk(20'd1000, 100, 3'b000);
		cmp("closures", {24'h0, c0 + 8'h01}, {24'h0, closures[0]});
		mchk(20'd600, 6, 3'b000);
		mchk(20'd1000, 6, 3'b001);
		mchk(20'd600, 100, 3'b000);
		wr(8'h00, cw(JUDGE_UPPER, MODE_PULSE, 5'h0, 5'h0, 8'h00));
		mchk(20'd1000, 20, 3'b000);
		$display("test pulse done");
		wr(8'h00, cw(JUDGE_UPPER, MODE_AUTO, 5'h0, 5'h0, 8'h0));
		mchk(20'd600, 6, 3'b000);
		wr(8'h30, 32'h7);
		rd(8'h30, 32'h0);
		wr(8'h34, 32'h1);
		rd(8'h34, 32'h1);
		mchk(20'd1000, 6, 3'b001);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(8'h34, 32'h0);
		tick(3);
		#1 cmp("irq", 32'h0, {31'h0, irq});
		wr(8'h34, 32'h1);
		mchk(20'd600, 6, 3'b000);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(8'h30, 32'h1);
		tick(3);
		#1 cmp("irq", 32'h0, {31'h0, irq});
		rd(8'h30, 32'h0);
		$display("test interrupt done");
		results;
	end
endmodule: speed_limit_comparator_outputs_tb_top
